// ===== adc_seq_map.vh
`ifndef ADC_SEQ_MAP_VH
`define ADC_SEQ_MAP_VH

// register indices; byte address on the bus is four times the index
`define IDX_CTL_TWO 5'h02
`define IDX_CTL_THREE 5'h03
`define IDX_CTL_FOUR 5'h04
`define IDX_CTL_FIVE 5'h05
`define IDX_STATUS_ZERO 5'h06
`define IDX_RESULT_BASE 5'h10
`define IDX_RESULT_SIX_HIGH 5'h1C
`define IDX_RESULT_SIX_LOW 5'h1D
`define IDX_RESULT_SEVEN_HIGH 5'h1E
`define IDX_RESULT_SEVEN_LOW 5'h1F

// status register fields
`define STAT_SEQ_DONE_BIT 7
`define STAT_TRIG_OVR_BIT 5
`define STAT_RES_OVR_BIT 4
`define STAT_CNT_MSB 2
`define STAT_CNT_LSB 0

// control two fields
`define CTL2_FAST_CLEAR_BIT 6
`define CTL2_TRIG_POL_BIT 4
`define CTL2_LEVEL_SEL_BIT 3
`define CTL2_TRIG_EN_BIT 2
// control three fields
`define CTL3_LEN_MSB 6
`define CTL3_LEN_LSB 3
`define CTL3_FIFO_BIT 2
// control four fields
`define CTL4_TIME_MSB 4
`define CTL4_TIME_LSB 0
// control five fields
`define CTL5_SCAN_BIT 5
`define CTL5_MULT_BIT 4
`define CTL5_CHAN_MSB 2
`define CTL5_CHAN_LSB 0

// reset values
`define CTL_RESET 8'h00
`define STATUS_RESET 8'h00

// least conversion time in clock cycles, added to the control four field
`define CONV_MIN_CYCLES 6'h02
`define SEQ_MAX_LEN 4'h8

`endif

// ===== adc_sequence_status_results.v
`timescale 1ns/1ps
`default_nettype none

`include "adc_seq_map.vh"

// Contract
// - set done flag when sequence finishes
// - scan mode sets flag after every sequence
// - clear done flag: write one, control five
// - fast clear: result read clears done flag
// - edge mode: trigger while busy sets overrun
// - clear overrun: write one, control five
// - control two-four write aborts, clears overrun
// - status shows flags and three-bit counter
// - status writes never touch counter bits
// - registers decode at base plus offset
module adc_sequence_status_results #(
  parameter [31:0] BASE_ADDR = 32'h0000_0000
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire pready,
  output reg [31:0] prdata,
  output reg pslverr,
  input wire ext_trigger,
  input wire [9:0] analog_code,
  output reg [2:0] analog_chan,
  output wire seq_busy
);

  reg [7:0] ctl_two_q;
  reg [7:0] ctl_three_q;
  reg [7:0] ctl_four_q;
  reg [7:0] ctl_five_q;
  reg sequence_complete_flag_q;
  reg sequence_complete_flag_d;
  reg trigger_overrun_flag_q;
  reg trigger_overrun_flag_d;
  reg result_overrun_flag_q;
  reg result_overrun_flag_d;
  reg armed_q;
  reg [7:0] unread_q;
  reg [9:0] result_mem [0:7];

  wire [4:0] idx;
  wire hit;
  wire wr_acc;
  wire rd_acc;
  wire wr_ctl234;
  wire wr_ctl5;
  wire wr_stat;
  wire rd_result;
  wire rd_low;
  wire [7:0] wbyte;
  wire fast_clear_enable;
  wire trigger_level_edge_select;
  wire trig_en;
  wire fifo_mode;
  wire [3:0] len_code;
  wire [3:0] seq_len;
  wire [5:0] conv_cycles;
  wire trig_level;
  wire trig_rise;
  wire trig_fall;
  wire trig_active_edge;
  wire trig_active_level;
  wire seq_start;
  wire conv_done;
  wire seq_done;
  wire [2:0] slot;
  wire [2:0] chan;
  wire [2:0] conversion_counter;

  // status reset image; each flag takes its own bit of it
  localparam [7:0] STAT_RESET_VAL = `STATUS_RESET;

  // true when the word index names a result byte
  function is_result;
    input [4:0] i;
    begin
      is_result = (i[4:3] == `IDX_RESULT_BASE >> 3) ||
        (i[4:3] == 2'b11);
    end
  endfunction

  // true when the word index names any implemented register
  function is_mapped;
    input [4:0] i;
    begin
      is_mapped = is_result(i) ||
        (i >= `IDX_CTL_TWO && i <= `IDX_STATUS_ZERO);
    end
  endfunction

  // only bits above the module window are compared against the base
  assign idx = paddr[6:2];
  assign hit = (paddr[31:7] == BASE_ADDR[31:7]);
  assign wr_acc = ce & psel & penable & pwrite & hit & is_mapped(idx);
  assign rd_acc = ce & psel & penable & ~pwrite & hit & is_mapped(idx);
  // a write without the low lane enabled stores nothing
  assign wbyte = pstrb[0] ? pwdata[7:0] : 8'h00;
  assign wr_ctl234 = wr_acc & pstrb[0] &
    ((idx == `IDX_CTL_TWO) || (idx == `IDX_CTL_THREE) ||
     (idx == `IDX_CTL_FOUR));
  assign wr_ctl5 = wr_acc & pstrb[0] & (idx == `IDX_CTL_FIVE);
  assign wr_stat = wr_acc & pstrb[0] & (idx == `IDX_STATUS_ZERO);
  assign rd_result = rd_acc & is_result(idx);
  assign rd_low = rd_result & idx[0];

  // zero-wait slave: answer data is prepared during the setup cycle
  assign pready = 1'b1;

  assign fast_clear_enable = ctl_two_q[`CTL2_FAST_CLEAR_BIT];
  assign trigger_level_edge_select = ctl_two_q[`CTL2_LEVEL_SEL_BIT];
  assign trig_en = ctl_two_q[`CTL2_TRIG_EN_BIT];
  assign fifo_mode = ctl_three_q[`CTL3_FIFO_BIT];
  assign len_code = ctl_three_q[`CTL3_LEN_MSB:`CTL3_LEN_LSB];
  // code zero and codes above the channel count mean eight conversions
  assign seq_len = (len_code == 4'h0 || len_code > `SEQ_MAX_LEN) ?
    `SEQ_MAX_LEN : len_code;
  assign conv_cycles = {1'b0, ctl_four_q[`CTL4_TIME_MSB:`CTL4_TIME_LSB]} +
    `CONV_MIN_CYCLES;
  assign conversion_counter = slot;

  trig_sync u_trig_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .pin(ext_trigger),
    .level(trig_level),
    .rise(trig_rise),
    .fall(trig_fall)
  );

  // polarity bit picks the active edge or level
  assign trig_active_edge = ctl_two_q[`CTL2_TRIG_POL_BIT] ? trig_rise :
    trig_fall;
  assign trig_active_level = ~(trig_level ^ ctl_two_q[`CTL2_TRIG_POL_BIT]);

  // without a trigger, the control five write starts at once; with one,
  // it only arms and the trigger starts the sequence
  assign seq_start = (wr_ctl5 & ~trig_en) |
    (armed_q & trig_en & ~seq_busy & ~wr_ctl5 & ~wr_ctl234 &
     (trigger_level_edge_select ? trig_active_level : trig_active_edge));

  conv_sequencer u_conv_sequencer (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .start(seq_start),
    .abort(wr_ctl234),
    .scan(ctl_five_q[`CTL5_SCAN_BIT]),
    .fifo(fifo_mode),
    .mult(ctl_five_q[`CTL5_MULT_BIT]),
    .len(seq_len),
    .first_chan(ctl_five_q[`CTL5_CHAN_MSB:`CTL5_CHAN_LSB]),
    .conv_cycles(conv_cycles),
    .busy(seq_busy),
    .conv_done(conv_done),
    .seq_done(seq_done),
    .slot(slot),
    .chan(chan)
  );

  // control registers and trigger arming
  always @(posedge clk) begin
    if (rst) begin
      ctl_two_q <= `CTL_RESET;
      ctl_three_q <= `CTL_RESET;
      ctl_four_q <= `CTL_RESET;
      ctl_five_q <= `CTL_RESET;
      armed_q <= 1'b0;
      analog_chan <= 3'h0;
    end else if (ce) begin
      analog_chan <= chan;
      if (wr_acc && pstrb[0] && idx == `IDX_CTL_TWO) begin
        ctl_two_q <= wbyte;
      end
      if (wr_acc && pstrb[0] && idx == `IDX_CTL_THREE) begin
        ctl_three_q <= wbyte;
      end
      if (wr_acc && pstrb[0] && idx == `IDX_CTL_FOUR) begin
        ctl_four_q <= wbyte;
      end
      if (wr_ctl5) begin
        ctl_five_q <= wbyte;
      end
      // a trigger-started non-scan sequence needs a fresh control five write
      if (wr_ctl234) begin
        armed_q <= 1'b0;
      end else if (wr_ctl5) begin
        armed_q <= 1'b1;
      end else if (seq_done && !ctl_five_q[`CTL5_SCAN_BIT]) begin
        armed_q <= 1'b0;
      end
    end
  end

  // flag next values; every set term is applied after the clears so that
  // an event in the clearing cycle is never lost, save a trigger overrun during a control two-four write
  always @* begin
    sequence_complete_flag_d = sequence_complete_flag_q;
    trigger_overrun_flag_d = trigger_overrun_flag_q;
    result_overrun_flag_d = result_overrun_flag_q;
    if (wr_stat && wbyte[`STAT_SEQ_DONE_BIT]) begin
      sequence_complete_flag_d = 1'b0;
    end
    if (wr_ctl5) begin
      sequence_complete_flag_d = 1'b0;
      trigger_overrun_flag_d = 1'b0;
    end
    if (rd_result && fast_clear_enable) begin
      sequence_complete_flag_d = 1'b0;
    end
    if (wr_stat && wbyte[`STAT_TRIG_OVR_BIT]) begin
      trigger_overrun_flag_d = 1'b0;
    end
    if (wr_ctl234) begin
      trigger_overrun_flag_d = 1'b0;
    end
    if (wr_stat && wbyte[`STAT_RES_OVR_BIT]) begin
      result_overrun_flag_d = 1'b0;
    end
    // scan mode reaches here once per finished sequence
    if (seq_done) begin
      sequence_complete_flag_d = 1'b1;
    end
    if (trig_en && !trigger_level_edge_select && trig_active_edge &&
        seq_busy && !wr_ctl234) begin
      trigger_overrun_flag_d = 1'b1;
    end
    // fifo mode: a result lands on a slot whose previous value is unread
    if (conv_done && fifo_mode && unread_q[slot]) begin
      result_overrun_flag_d = 1'b1;
    end
  end

  // status flags; the counter bits are not stored here at all, so a status
  // write cannot reach them
  always @(posedge clk) begin
    if (rst) begin
      sequence_complete_flag_q <= STAT_RESET_VAL[`STAT_SEQ_DONE_BIT];
      trigger_overrun_flag_q <= STAT_RESET_VAL[`STAT_TRIG_OVR_BIT];
      result_overrun_flag_q <= STAT_RESET_VAL[`STAT_RES_OVR_BIT];
    end else if (ce) begin
      sequence_complete_flag_q <= sequence_complete_flag_d;
      trigger_overrun_flag_q <= trigger_overrun_flag_d;
      result_overrun_flag_q <= result_overrun_flag_d;
    end
  end

  // result storage and per-slot unread marks
  always @(posedge clk) begin
    if (rst) begin
      unread_q <= 8'h00;
    end else if (ce) begin
      if (rd_low) begin
        unread_q[idx[3:1]] <= 1'b0;
      end
      // a new result wins over a read of the same slot in one cycle
      if (conv_done) begin
        result_mem[slot] <= analog_code;
        unread_q[slot] <= 1'b1;
      end
    end
  end

  // read data is latched in the setup cycle and held through the access
  always @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce && psel && !penable) begin
      prdata <= 32'h0000_0000;
      pslverr <= ~(hit & is_mapped(idx));
      if (!pwrite && hit) begin
        case (idx)
          `IDX_CTL_TWO: prdata[7:0] <= ctl_two_q;
          `IDX_CTL_THREE: prdata[7:0] <= ctl_three_q;
          `IDX_CTL_FOUR: prdata[7:0] <= ctl_four_q;
          `IDX_CTL_FIVE: prdata[7:0] <= ctl_five_q;
          `IDX_STATUS_ZERO: begin
            // readable at any time; bits 6 and 3 read zero
            prdata[`STAT_SEQ_DONE_BIT] <= sequence_complete_flag_q;
            prdata[`STAT_TRIG_OVR_BIT] <= trigger_overrun_flag_q;
            prdata[`STAT_RES_OVR_BIT] <= result_overrun_flag_q;
            prdata[`STAT_CNT_MSB:`STAT_CNT_LSB] <= conversion_counter;
          end
          default: begin
            if (is_result(idx) && idx[0]) begin
              prdata[7:0] <= result_mem[idx[3:1]][7:0];
            end else if (is_result(idx)) begin
              prdata[1:0] <= result_mem[idx[3:1]][9:8];
            end
          end
        endcase
      end
    end
  end

endmodule // adc_sequence_status_results

`default_nettype wire

// ===== conv_sequencer.v
`timescale 1ns/1ps
`default_nettype none

`include "adc_seq_map.vh"

// walks one conversion sequence: a fixed time per conversion, then the next
// result slot, and the next channel only when mult is set; in scan mode it wraps round without stopping
module conv_sequencer (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire start,
  input wire abort,
  input wire scan,
  input wire fifo,
  input wire mult,
  input wire [3:0] len,
  input wire [2:0] first_chan,
  input wire [5:0] conv_cycles,
  output reg busy,
  output wire conv_done,
  output wire seq_done,
  output reg [2:0] slot,
  output reg [2:0] chan
);

  localparam ST_IDLE = 1'b0;
  localparam ST_CONV = 1'b1;

  reg [5:0] timer_q;
  reg [3:0] count_q;
  wire last;

  assign conv_done = ce & busy & (timer_q == 6'h01);
  assign last = (count_q == len - 4'h1);
  assign seq_done = conv_done & last;

  // abort beats start, start beats the running sequence
  always @(posedge clk) begin
    if (rst) begin
      busy <= ST_IDLE;
      timer_q <= 6'h00;
      count_q <= 4'h0;
      slot <= 3'h0;
      chan <= 3'h0;
    end else if (ce) begin
      if (abort) begin
        busy <= ST_IDLE;
      end else if (start) begin
        busy <= ST_CONV;
        timer_q <= conv_cycles;
        count_q <= 4'h0;
        chan <= first_chan;
        if (!fifo) begin
          slot <= 3'h0;
        end
      end else begin
        case (busy)
          ST_IDLE: begin
            timer_q <= 6'h00;
          end
          ST_CONV: begin
            if (timer_q != 6'h01) begin
              timer_q <= timer_q - 6'h01;
            end else begin
              timer_q <= conv_cycles;
              // non-fifo scans restart filling from slot zero
              slot <= (last && !fifo) ? 3'h0 : slot + 3'h1;
              if (last) begin
                count_q <= 4'h0;
                chan <= first_chan;
                busy <= scan ? ST_CONV : ST_IDLE;
              end else begin
                count_q <= count_q + 4'h1;
                chan <= mult ? chan + 3'h1 : chan;
              end
            end
          end
          default: begin
            busy <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule // conv_sequencer

`default_nettype wire

// ===== seq_stat_chk.sv
`timescale 1ns/1ps
`default_nettype none
module seq_stat_chk #(
  parameter [31:0] BASE_ADDR = 32'h0000_0000
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  input wire pready,
  input wire [31:0] prdata,
  input wire pslverr,
  input wire seq_busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // decoded bus phases; busy excluded where a set could win the cycle
  wire [4:0] idx = paddr[6:2];
  wire inb = paddr[31:7] == BASE_ADDR[31:7];
  wire su = psel && !penable && ce;
  wire wr = psel && penable && pwrite && pstrb[0] && ce && inb;
  wire st_rd = su && !pwrite && inb && idx == 5'h06;
  wire ctl = idx >= 5'h02 && idx <= 5'h04;
  wire bad = !inb || idx < 5'h02 || (idx > 5'h06 && idx < 5'h10);
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_upper_zero: assert property (prdata[31:8] == 24'h0)
    else $error("prdata upper bits set");
  a_unmapped_err: assert property (
    su && bad |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_high_byte: assert property (
    su && !pwrite && inb && idx[4] && !idx[0] |=> prdata[7:2] == 6'h00)
    else $error("high byte upper bits set");
  a_reset_idle: assert property (
    $fell(rst) |-> !seq_busy && !pslverr)
    else $error("not idle after reset");
  a_flags_sticky: assert property (
    st_rd ##1 1'b1 ##2 st_rd |=>
    ($past(prdata[7:0], 3) & 8'hA0 & ~prdata[7:0]) == 8'h00)
    else $error("flag dropped without clear");
  // the next setup comes two cycles after a write's access edge
  a_start_clear: assert property (
    wr && idx == 5'h05 && !seq_busy ##2 st_rd |=> !prdata[7])
    else $error("done flag kept after start");
  a_status_w1c: assert property (
    wr && idx == 5'h06 && pwdata[7] && pwdata[5] && !seq_busy ##2 st_rd
    |=> !prdata[7] && !prdata[5])
    else $error("write one did not clear");
  a_abort_idle: assert property (wr && ctl |=> !seq_busy)
    else $error("sequence not aborted");
  a_abort_ovr: assert property (
    wr && ctl ##2 st_rd |=> !prdata[5])
    else $error("overrun kept after abort");
endmodule // seq_stat_chk
bind adc_sequence_status_results seq_stat_chk #(.BASE_ADDR(BASE_ADDR)) chk_i (
  .clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .seq_busy(seq_busy));
`default_nettype wire

// ===== tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_map.vh"
module tb;
  localparam [31:0] BASE = 32'h0000_0400;
  localparam [4:0] ST = `IDX_STATUS_ZERO;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic trig = 1'b0;
  logic [9:0] code = 10'h000;
  logic [31:0] base_q = BASE;
  logic [7:0] r;
  logic e;
  wire pready;
  wire pslverr;
  wire seq_busy;
  wire [31:0] prdata;
  wire [2:0] chan;
  int num_errors = 0;
  int n_compared = 0;
  always #5 clk = ~clk;
  // code carries the channel so each result slot is recognisable
  always @(posedge clk) code <= {chan, 1'b1, ~chan, 3'h5};
  adc_sequence_status_results #(.BASE_ADDR(BASE)) uut (
    .clk(clk), .rst(rst), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .ext_trigger(trig), .analog_code(code), .analog_chan(chan),
    .seq_busy(seq_busy));
  task wrap_up;
    if (num_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] x, input logic [7:0] g);
    n_compared++;
    if (g !== x) begin
      $display("mismatch %s expected %h seen %h", nm, x, g);
      num_errors++;
    end
  endtask
  // one transfer, entered just past an edge; trailing idle cycle keeps
  // a second call from reassigning psel in the same step
  task apb(input logic w, input logic [4:0] i, input logic [7:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= base_q | {25'h0, i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    // wait states are the slave's business; pready or the bound of 50 ends the wait
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      num_errors++;
      wrap_up();
    end
    r = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task rd(input logic [4:0] i, input logic [7:0] m, input logic [7:0] x,
    input string nm);
    apb(1'b0, i, 8'h00);
    chk(nm, x, r & m);
  endtask
  task wait_busy(input logic lvl);
    int k;
    k = 0;
    while (seq_busy !== lvl && k < 2000) begin
      @(posedge clk);
      k++;
    end
    if (k == 2000) begin
      num_errors++;
      wrap_up();
    end
  endtask
  task poll_done;
    int k;
    k = 0;
    r = 8'h00;
    while (r[7] !== 1'b1 && k < 100) begin
      apb(1'b0, ST, 8'h00);
      k++;
    end
    chk("scan flag", 8'h80, r & 8'h80);
  endtask
  task pulse;
    trig <= 1'b1;
    repeat (8) @(posedge clk);
    trig <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  // rising edge starts a run, a second edge lands while it is busy
  task make_ovr;
    apb(1'b1, `IDX_CTL_TWO, 8'h14);
    apb(1'b1, `IDX_CTL_FIVE, 8'h10);
    pulse();
    wait_busy(1'b1);
    pulse();
    rd(ST, 8'h20, 8'h20, "overrun set");
  endtask
  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(ST, 8'hFF, `STATUS_RESET, "status reset");
    apb(1'b0, 5'h07, 8'h00);
    chk("unmapped err", 8'h01, {7'h0, e});
    base_q = 32'h0;
    apb(1'b0, ST, 8'h00);
    chk("off base err", 8'h01, {7'h0, e});
    base_q = BASE;
    apb(1'b1, `IDX_CTL_FOUR, 8'h03);
    apb(1'b1, `IDX_CTL_THREE, 8'h40);
    apb(1'b1, `IDX_CTL_FIVE, 8'h10);
    wait_busy(1'b1);
    wait_busy(1'b0);
    rd(ST, 8'hFF, 8'h80, "done flag");
    rd(`IDX_RESULT_SIX_HIGH, 8'hFF, 8'h03, "six high");
    rd(`IDX_RESULT_SIX_LOW, 8'hFF, 8'h4D, "six low");
    rd(`IDX_RESULT_SEVEN_HIGH, 8'hFF, 8'h03, "seven high");
    rd(`IDX_RESULT_SEVEN_LOW, 8'hFF, 8'hC5, "seven low");
    rd(ST, 8'hFF, 8'h80, "no fast clear");
    pstrb <= 4'hE;
    apb(1'b1, ST, 8'hFF);
    pstrb <= 4'hF;
    rd(ST, 8'hFF, 8'h80, "strobe off");
    apb(1'b1, ST, 8'h00);
    rd(ST, 8'hFF, 8'h80, "write zero");
    apb(1'b1, ST, 8'hFF);
    rd(ST, 8'hFF, 8'h00, "write one");
    // fifo run of three leaves the counter nonzero
    apb(1'b1, `IDX_CTL_THREE, 8'h1C);
    apb(1'b1, `IDX_CTL_FIVE, 8'h10);
    wait_busy(1'b1);
    wait_busy(1'b0);
    rd(ST, 8'hEF, 8'h83, "counter");
    apb(1'b1, ST, 8'hFF);
    rd(ST, 8'hEF, 8'h03, "counter kept");
    apb(1'b1, `IDX_CTL_TWO, 8'h40);
    apb(1'b1, `IDX_CTL_THREE, 8'h40);
    apb(1'b1, `IDX_CTL_FIVE, 8'h10);
    wait_busy(1'b1);
    wait_busy(1'b0);
    rd(ST, 8'h80, 8'h80, "done again");
    apb(1'b1, `IDX_CTL_FIVE, 8'h10);
    rd(ST, 8'h80, 8'h00, "restart clear");
    wait_busy(1'b0);
    rd(`IDX_RESULT_SIX_LOW, 8'hFF, 8'h4D, "six low fast");
    rd(ST, 8'h80, 8'h00, "fast clear");
    apb(1'b1, `IDX_CTL_FIVE, 8'h30);
    poll_done();
    apb(1'b1, ST, 8'h80);
    poll_done();
    apb(1'b1, `IDX_CTL_THREE, 8'h40);
    chk("abort busy", 8'h00, {7'h0, seq_busy});
    make_ovr();
    rd(ST, 8'h20, 8'h20, "overrun sticky");
    apb(1'b1, ST, 8'h20);
    rd(ST, 8'h20, 8'h00, "overrun w1c");
    make_ovr();
    apb(1'b1, `IDX_CTL_FOUR, 8'h03);
    rd(ST, 8'h20, 8'h00, "overrun abort");
    make_ovr();
    apb(1'b1, `IDX_CTL_FIVE, 8'h10);
    rd(ST, 8'h20, 8'h00, "overrun restart");
    // level mode: the pin starts the run, no overrun while it stays high
    apb(1'b1, `IDX_CTL_TWO, 8'h1C);
    apb(1'b1, `IDX_CTL_FIVE, 8'h10);
    pulse();
    chk("level busy", 8'h01, {7'h0, seq_busy});
    rd(ST, 8'h20, 8'h00, "level no overrun");
    make_ovr();
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(ST, 8'hFF, 8'h00, "reset clears");
    wrap_up();
  end
endmodule // tb
`default_nettype wire

// ===== trig_sync.v
`timescale 1ns/1ps
`default_nettype none

// three-stage synchroniser; the filtered level moves only when stages two
// and three agree, so a single-cycle glitch never reaches the edge detector
module trig_sync (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire pin,
  output reg level,
  output wire rise,
  output wire fall
);

  reg s1_q;
  reg s2_q;
  reg s3_q;
  reg level_d;

  // s1_q is read only by s2_q
  always @(posedge clk) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level <= 1'b0;
    end else if (ce) begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level <= level_d;
    end
  end

  // agreement filter
  always @* begin
    level_d = level;
    if (s2_q == s3_q) begin
      level_d = s3_q;
    end
  end

  assign rise = ce & level_d & ~level;
  assign fall = ce & ~level_d & level;

endmodule // trig_sync

`default_nettype wire
